// file: design/mifs_top.sv
`timescale 1ns/1ps
`include "mifs_consts.svh"
// What this block does
// RULE_01: phase A, B, C sag sets status bits 3, 4, 5.
// RULE_02: missing zero crossing on A, B, C sets bits 6, 7, 8.
// RULE_03: rising voltage zero crossing on A, B, C sets bits 9-11; falling ignored.
// RULE_04: with line-cycle mode on, end of half-cycle integration sets bit 12.
// RULE_05: bit 13 marks reset or supply low; defaults one, others zero.
// RULE_06: a reset event restores all registers; software may trigger it.
// RULE_07: bit 13 reads high only one clock after a reset event.
// RULE_08: voltage sample above voltage peak threshold sets bit 14.
// RULE_09: current sample above current peak threshold sets bit 15.
// RULE_10: a new waveform sample ready sets bit 16.
// RULE_11: active power sign change on selected phases sets bit 17.
// RULE_12: reactive power sign change on selected phases sets bit 18.
// RULE_13: A crossing followed next by B instead of C sets bit 19.
// RULE_14: flags stay set until clear-on-read status is read, which clears them; the code also clears bits written as ones to the status register.
// RULE_15: interrupt pin pulled low while any set flag is enabled in the mask.
// RULE_16: bits 0, 1 flag energy bit-14 change; bit 2 apparent bit-15 rise.
// RULE_17: host reads the status register first to find the source.
// RULE_18: plain status read clears nothing; repeated events keep the flag set.
module mifs_top
	import mifs_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// supply monitor pin
	input wire logic supplyLowPin,
	// event sources
	input wire mifs_phase_t sagEvt,
	input wire mifs_phase_t crossTimeout,
	input wire mifs_phase_t voltSign,
	input wire logic lineCycleDone,
	input wire logic sampleValid,
	input wire logic [SAMPLE_W-1:0] voltSample,
	input wire logic [SAMPLE_W-1:0] curSample,
	input wire logic waveformReady,
	input wire mifs_phase_t activeSign,
	input wire mifs_phase_t reactiveSign,
	input wire mifs_phase_t activeBit14,
	input wire mifs_phase_t reactiveBit14,
	input wire mifs_phase_t apparentBit15,
	// open-drain interrupt
	output logic irqNOut,
	output logic irqNOe
);
	mifs_evt_if evtIf();
	mifs_word_t mask_q, ctrl_q, vPeak_q, iPeak_q, flags, clrMask, readMux;
	logic supLowS1_q, supLowS2_q, swRst_q, resetEvt;
	logic setup, access, hitMask, hitStatus, hitClrRead, hitCtrl, hitVpk, hitIpk, mapped;
	logic [31:0] prdata_q;

	function automatic logic hitIdx(input logic [11:0] a, input logic [7:0] idx);
		hitIdx = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
	endfunction

	// ----------------------------------------
	// reset events
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			supLowS1_q <= 1'b0;
			supLowS2_q <= 1'b0;
		end else begin
			supLowS1_q <= supplyLowPin;
			supLowS2_q <= supLowS1_q;
		end
	end

	// supply low holds the block in reset for as long as it lasts
	assign resetEvt = rst || swRst_q || supLowS2_q; // [RULE_05] [RULE_06]

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign hitMask = hitIdx(paddr, `MIFS_IDX_MASK);
	assign hitStatus = hitIdx(paddr, `MIFS_IDX_STATUS);
	assign hitClrRead = hitIdx(paddr, `MIFS_IDX_CLR_READ);
	assign hitCtrl = hitIdx(paddr, `MIFS_IDX_CTRL);
	assign hitVpk = hitIdx(paddr, `MIFS_IDX_VPEAK);
	assign hitIpk = hitIdx(paddr, `MIFS_IDX_IPEAK);
	assign mapped = hitMask || hitStatus || hitClrRead || hitCtrl || hitVpk || hitIpk;

	// zero wait states: read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata = prdata_q;

	always_comb begin
		readMux = 24'h000000;
		if (hitMask) begin
			readMux = mask_q;
		end else if (hitStatus || hitClrRead) begin
			readMux = flags; // [RULE_17]
		end else if (hitCtrl) begin
			readMux = ctrl_q;
		end else if (hitVpk) begin
			readMux = vPeak_q;
		end else if (hitIpk) begin
			readMux = iPeak_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (resetEvt) begin
			prdata_q <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata_q <= {8'h00, readMux};
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (resetEvt) begin
			mask_q <= `MIFS_MASK_RST; // [RULE_06]
		end else if (access && pwrite && hitMask) begin
			mask_q <= pwdata[23:0] & `MIFS_MASK_VALID;
		end
	end

	always_ff @(posedge mclk) begin
		if (resetEvt) begin
			ctrl_q <= `MIFS_CTRL_RST; // [RULE_06]
		end else if (access && pwrite && hitCtrl) begin
			ctrl_q <= pwdata[23:0] & `MIFS_CTRL_VALID & ~(24'h000001 << `MIFS_C_SWRST);
		end
	end

	always_ff @(posedge mclk) begin
		if (resetEvt) begin
			vPeak_q <= `MIFS_PEAK_RST;
			iPeak_q <= `MIFS_PEAK_RST;
		end else if (access && pwrite) begin
			if (hitVpk) begin
				vPeak_q <= pwdata[23:0];
			end
			if (hitIpk) begin
				iPeak_q <= pwdata[23:0];
			end
		end
	end

	// one-cycle software reset strobe
	always_ff @(posedge mclk) begin
		if (resetEvt) begin
			swRst_q <= 1'b0;
		end else begin
			swRst_q <= access && pwrite && hitCtrl && pwdata[`MIFS_C_SWRST]; // [RULE_06]
		end
	end

	// ----------------------------------------
	// clearing
	// ----------------------------------------
	// a clear-on-read clears only bits that were returned, so an event landing
	// between setup and access is never lost
	always_comb begin
		clrMask = 24'h000000;
		if (access && !pwrite && hitClrRead) begin
			clrMask = prdata_q[23:0]; // [RULE_14]
		end else if (access && pwrite && hitStatus) begin
			clrMask = pwdata[23:0];
		end
	end

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	mifs_event_detect #(.SAMPLE_W(SAMPLE_W)) uDetect (
		.mclk(mclk),
		.resetEvt(resetEvt),
		.lineCycMode(ctrl_q[`MIFS_C_LINE_MODE]),
		.phase_term_select(ctrl_q[`MIFS_C_TERM_HI:`MIFS_C_TERM_LO]),
		.vPeakThr(vPeak_q[SAMPLE_W-1:0]),
		.iPeakThr(iPeak_q[SAMPLE_W-1:0]),
		.sagEvt(sagEvt),
		.crossTimeout(crossTimeout),
		.voltSign(voltSign),
		.lineCycleDone(lineCycleDone),
		.sampleValid(sampleValid),
		.voltSample(voltSample),
		.curSample(curSample),
		.waveformReady(waveformReady),
		.activeSign(activeSign),
		.reactiveSign(reactiveSign),
		.activeBit14(activeBit14),
		.reactiveBit14(reactiveBit14),
		.apparentBit15(apparentBit15),
		.ev(evtIf.src)
	);

	mifs_flag_store uFlags (
		.mclk(mclk),
		.resetEvt(resetEvt),
		.ev(evtIf.dst),
		.clrMask(clrMask),
		.flags(flags)
	);

	// ----------------------------------------
	// interrupt pin
	// ----------------------------------------
	assign irqNOut = 1'b0;
	assign irqNOe = |(flags & mask_q); // [RULE_15]

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence clrReadSeq;
		setup && !pwrite && hitClrRead ##1 access && !pwrite && hitClrRead;
	endsequence

	sequence crossAThenB;
		evtIf.evt[`MIFS_B_RISE_CROSS +: 3] == 3'b001 ##1
		evtIf.evt[`MIFS_B_RISE_CROSS +: 3] == 3'b010;
	endsequence

	sequence resetFlagPulse;
		flags[`MIFS_B_RESET] ##1 !flags[`MIFS_B_RESET];
	endsequence

	AST_RESET_PULSE: assert property (@(posedge mclk) disable iff (rst) // [RULE_07]
		$past(rst) && !swRst_q && !supLowS2_q |-> flags[`MIFS_B_RESET] ##1
		(!flags[`MIFS_B_RESET] || $past(resetEvt)))
		else $error("reset flag not a single cycle after release");

	AST_SWRST: assert property (@(posedge mclk) disable iff (rst) // [RULE_06]
		swRst_q |=> flags[`MIFS_B_RESET] && mask_q == `MIFS_MASK_RST && (flags & ~24'h002000) == 0)
		else $error("software reset did not restore defaults");

	AST_IRQ: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_15]
		(|(flags & mask_q & `MIFS_MASK_VALID)) == irqNOe)
		else $error("interrupt pin does not follow masked flags");

	AST_STICKY: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_18]
		clrMask == 24'h000000 |=> ((flags & $past(flags) & 24'h0FDFFF) == ($past(flags) & 24'h0FDFFF)) || resetEvt)
		else $error("flag dropped without a clear");

	AST_SET_WINS: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_14]
		evtIf.evt[`MIFS_B_SEQ_ERR:0] != 20'h00000 |=> resetEvt ||
		(($past(evtIf.evt) & ~flags & 24'h0FDFFF) == 24'h000000))
		else $error("event lost");

	AST_RCLEAR: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_14]
		clrReadSeq |=> resetEvt || ((flags & $past(clrMask) & ~$past(evtIf.evt) & 24'h0FDFFF) == 0))
		else $error("clear-on-read left a reported flag set");

	AST_PEAK_V: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_08]
		sampleValid && voltSample > vPeak_q[SAMPLE_W-1:0] |=> flags[`MIFS_B_VOLT_PEAK] || resetEvt)
		else $error("voltage peak not flagged");

	AST_PEAK_I: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_09]
		sampleValid && curSample > iPeak_q[SAMPLE_W-1:0] |=> flags[`MIFS_B_CUR_PEAK] || resetEvt)
		else $error("current peak not flagged");

	AST_SEQ_ORDER: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_13]
		crossAThenB |=> flags[`MIFS_B_SEQ_ERR] || resetEvt)
		else $error("phase order error not flagged");

	AST_LINE_MODE: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_04]
		lineCycleDone && !ctrl_q[`MIFS_C_LINE_MODE] |-> !evtIf.evt[`MIFS_B_LINE_DONE])
		else $error("line-cycle flag outside line-cycle mode");

	AST_SOFT_PULSE: assert property (@(posedge mclk) disable iff (rst) // [RULE_07]
		swRst_q && !supLowS2_q |=> resetFlagPulse)
		else $error("reset flag not a single cycle after software reset");

	AST_SAG_SET: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_01]
		(|sagEvt) |=> (flags[`MIFS_B_SAG +: 3] & $past(sagEvt)) == $past(sagEvt))
		else $error("sag not flagged");

	AST_TIMEOUT_SET: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_02]
		(|crossTimeout) |=> (flags[`MIFS_B_CROSS_TO +: 3] & $past(crossTimeout)) == $past(crossTimeout))
		else $error("missing crossing not flagged");

	AST_FALL_QUIET: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_03]
		(voltSign & ~$past(voltSign)) == 3'h0 |-> evtIf.evt[`MIFS_B_RISE_CROSS +: 3] == 3'h0)
		else $error("crossing flagged without a rising edge");

	AST_WAVE_SET: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_10]
		waveformReady |=> flags[`MIFS_B_WAVE_READY])
		else $error("waveform sample not flagged");

	AST_ACT_FLIP: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_11]
		(|((activeSign ^ $past(activeSign)) & ctrl_q[`MIFS_C_TERM_HI:`MIFS_C_TERM_LO])) |=>
		flags[`MIFS_B_ACT_FLIP])
		else $error("active sign change not flagged");

	AST_REACT_FLIP: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_12]
		(|((reactiveSign ^ $past(reactiveSign)) & ctrl_q[`MIFS_C_TERM_HI:`MIFS_C_TERM_LO])) |=>
		flags[`MIFS_B_REACT_FLIP])
		else $error("reactive sign change not flagged");

	AST_ACT_HALF: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_16]
		(activeBit14 != $past(activeBit14)) |=> flags[`MIFS_B_ACT_HALF])
		else $error("active energy half mark not flagged");

	AST_APP_HALF: assert property (@(posedge mclk) disable iff (resetEvt) // [RULE_16]
		(|(apparentBit15 & ~$past(apparentBit15))) |=> flags[`MIFS_B_APP_HALF])
		else $error("apparent energy half mark not flagged");
endmodule

// file: design/mifs_consts.svh
`ifndef MIFS_CONSTS_SVH
`define MIFS_CONSTS_SVH

// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define MIFS_IDX_MASK 8'h18
`define MIFS_IDX_STATUS 8'h19
`define MIFS_IDX_CLR_READ 8'h1A
`define MIFS_IDX_CTRL 8'h20
`define MIFS_IDX_VPEAK 8'h21
`define MIFS_IDX_IPEAK 8'h22

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define MIFS_B_ACT_HALF 0
`define MIFS_B_REACT_HALF 1
`define MIFS_B_APP_HALF 2
`define MIFS_B_SAG 3
`define MIFS_B_CROSS_TO 6
`define MIFS_B_RISE_CROSS 9
`define MIFS_B_LINE_DONE 12
`define MIFS_B_RESET 13
`define MIFS_B_VOLT_PEAK 14
`define MIFS_B_CUR_PEAK 15
`define MIFS_B_WAVE_READY 16
`define MIFS_B_ACT_FLIP 17
`define MIFS_B_REACT_FLIP 18
`define MIFS_B_SEQ_ERR 19

// ----------------------------------------
// control register fields
// ----------------------------------------
`define MIFS_C_SWRST 0
`define MIFS_C_LINE_MODE 1
`define MIFS_C_TERM_LO 2
`define MIFS_C_TERM_HI 4

// ----------------------------------------
// reset values and valid masks
// ----------------------------------------
`define MIFS_STATUS_RST 24'h002000
`define MIFS_MASK_RST 24'h000000
`define MIFS_MASK_VALID 24'h0FDFFF
`define MIFS_CTRL_RST 24'h00001C
`define MIFS_CTRL_VALID 24'h00001F
`define MIFS_PEAK_RST 24'h7FFFFF
`define MIFS_EVT_VALID 24'h0FDFFF

`endif

// file: design/mifs_pkg.sv
package mifs_pkg;
	typedef logic [23:0] mifs_word_t;
	typedef logic [2:0] mifs_phase_t;
	typedef enum logic {
		MIFS_SEQ_IDLE = 1'b0,
		MIFS_SEQ_SAW_A = 1'b1
	} mifs_seq_e;
endpackage

// file: design/mifs_evt_if.sv
`timescale 1ns/1ps
interface mifs_evt_if;
	import mifs_pkg::*;
	mifs_word_t evt;
	modport src (output evt);
	modport dst (input evt);
endinterface

// file: design/mifs_event_detect.sv
`timescale 1ns/1ps
`include "mifs_consts.svh"
module mifs_event_detect
	import mifs_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	// clock and reset event
	input wire logic mclk,
	input wire logic resetEvt,
	// configuration
	input wire logic lineCycMode,
	input wire mifs_phase_t phase_term_select,
	input wire logic [SAMPLE_W-1:0] vPeakThr,
	input wire logic [SAMPLE_W-1:0] iPeakThr,
	// raw event sources
	input wire mifs_phase_t sagEvt,
	input wire mifs_phase_t crossTimeout,
	input wire mifs_phase_t voltSign,
	input wire logic lineCycleDone,
	input wire logic sampleValid,
	input wire logic [SAMPLE_W-1:0] voltSample,
	input wire logic [SAMPLE_W-1:0] curSample,
	input wire logic waveformReady,
	input wire mifs_phase_t activeSign,
	input wire mifs_phase_t reactiveSign,
	input wire mifs_phase_t activeBit14,
	input wire mifs_phase_t reactiveBit14,
	input wire mifs_phase_t apparentBit15,
	// event pulses
	mifs_evt_if.src ev
);
	mifs_phase_t voltPrev_q, actPrev_q, reactPrev_q, aeP_q, reP_q, vaP_q;
	mifs_phase_t risingCross;
	mifs_seq_e seq_q;
	logic phase_sequence_error;

	// ----------------------------------------
	// previous levels for edge detection
	// ----------------------------------------
	// tracked through reset too, so a level already high at release
	// is not taken for a fresh edge
	always_ff @(posedge mclk) begin
		voltPrev_q <= voltSign;
		actPrev_q <= activeSign;
		reactPrev_q <= reactiveSign;
		aeP_q <= activeBit14;
		reP_q <= reactiveBit14;
		vaP_q <= apparentBit15;
	end

	// falling crossings are ignored on purpose
	assign risingCross = voltSign & ~voltPrev_q; // [RULE_03]

	// ----------------------------------------
	// phase order watch
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (resetEvt) begin
			seq_q <= MIFS_SEQ_IDLE;
		end else if (risingCross[0]) begin
			seq_q <= MIFS_SEQ_SAW_A;
		end else if (risingCross[1] || risingCross[2]) begin
			seq_q <= MIFS_SEQ_IDLE;
		end
	end

	// a crossing of B before C after A is out of order
	assign phase_sequence_error = (seq_q == MIFS_SEQ_SAW_A) && risingCross[1] && !risingCross[2]; // [RULE_13]

	// ----------------------------------------
	// event word
	// ----------------------------------------
	always_comb begin
		ev.evt = 24'h000000;
		ev.evt[`MIFS_B_ACT_HALF] = |(activeBit14 ^ aeP_q); // [RULE_16]
		ev.evt[`MIFS_B_REACT_HALF] = |(reactiveBit14 ^ reP_q); // [RULE_16]
		ev.evt[`MIFS_B_APP_HALF] = |(apparentBit15 & ~vaP_q); // [RULE_16]
		ev.evt[`MIFS_B_SAG +: 3] = sagEvt; // [RULE_01]
		ev.evt[`MIFS_B_CROSS_TO +: 3] = crossTimeout; // [RULE_02]
		ev.evt[`MIFS_B_RISE_CROSS +: 3] = risingCross; // [RULE_03]
		ev.evt[`MIFS_B_LINE_DONE] = lineCycMode && lineCycleDone; // [RULE_04]
		ev.evt[`MIFS_B_VOLT_PEAK] = sampleValid && (voltSample > vPeakThr); // [RULE_08]
		ev.evt[`MIFS_B_CUR_PEAK] = sampleValid && (curSample > iPeakThr); // [RULE_09]
		ev.evt[`MIFS_B_WAVE_READY] = waveformReady; // [RULE_10]
		ev.evt[`MIFS_B_ACT_FLIP] = |((activeSign ^ actPrev_q) & phase_term_select); // [RULE_11]
		ev.evt[`MIFS_B_REACT_FLIP] = |((reactiveSign ^ reactPrev_q) & phase_term_select); // [RULE_12]
		ev.evt[`MIFS_B_SEQ_ERR] = phase_sequence_error; // [RULE_13]
	end
endmodule

// file: design/mifs_flag_store.sv
`timescale 1ns/1ps
`include "mifs_consts.svh"
module mifs_flag_store
	import mifs_pkg::*;
(
	// clock and reset event
	input wire logic mclk,
	input wire logic resetEvt,
	// set and clear
	mifs_evt_if.dst ev,
	input wire mifs_word_t clrMask,
	// flags
	output mifs_word_t flags
);
	mifs_word_t sticky_q;
	logic rstFlag_q;

	// ----------------------------------------
	// sticky flags, set beats clear
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (resetEvt) begin
			sticky_q <= 24'h000000;
		end else begin
			sticky_q <= ((sticky_q & ~clrMask) | ev.evt) & `MIFS_EVT_VALID; // [RULE_14] [RULE_18]
		end
	end

	// high from one cycle after the reset event starts until one cycle after it ends
	always_ff @(posedge mclk) begin
		rstFlag_q <= resetEvt; // [RULE_05] [RULE_07]
	end

	always_comb begin
		flags = sticky_q;
		flags[`MIFS_B_RESET] = rstFlag_q;
	end
endmodule

// file: sim/mifs_host_model.sv
`timescale 1ns/1ps
module mifs_host_model (
	// clock
	input wire logic mclk,
	// apb master side
	output logic [11:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	initial begin
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
	end

	// ----------------------------------------
	// one apb transfer; now skips the leading edge
	// ----------------------------------------
	task automatic xfer(input logic now, input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		if (!now) begin
			@(posedge mclk);
		end
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// no wait count assumed, the bench watchdog bounds a hang
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// ----------------------------------------
	// service: status first, then clear-on-read copy
	// ----------------------------------------
	task automatic serviceIrq(output logic [31:0] st, output logic [31:0] rs);
		logic e;
		xfer(1'b0, 12'h064, 1'b0, 32'h0, st, e);
		xfer(1'b0, 12'h068, 1'b0, 32'h0, rs, e);
	endtask
endmodule

// file: sim/meter_interrupt_status_flags_tb.sv
`timescale 1ns/1ps
module meter_interrupt_status_flags_tb;
	import mifs_pkg::*;
	typedef struct {int code; logic [23:0] smp; logic [23:0] exp;} mifs_row_s;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] paddr;
	logic psel, penable, pwrite, pready, pslverr, irqNOut, irqNOe;
	logic [31:0] pwdata, prdata, rd, st;
	logic err;
	logic supplyLowPin = 1'b0;
	mifs_phase_t sagEvt = '0, crossTimeout = '0, voltSign = '0, activeSign = '0;
	mifs_phase_t reactiveSign = '0, activeBit14 = '0, reactiveBit14 = '0, apparentBit15 = '0;
	logic lineCycleDone = 1'b0, sampleValid = 1'b0, waveformReady = 1'b0;
	logic [23:0] voltSample = 24'h0, curSample = 24'h0;
	int failures = 0;
	int samplesChecked = 0;
	// one row per event source, two for the voltage peak (at and above threshold), codes decoded in fire
	mifs_row_s rows[20] = '{
		'{0, 0, 24'h000008}, '{1, 0, 24'h000010}, '{2, 0, 24'h000020},
		'{3, 0, 24'h000040}, '{4, 0, 24'h000080}, '{5, 0, 24'h000100},
		'{6, 0, 24'h000200}, '{8, 0, 24'h000800}, '{7, 0, 24'h000400},
		'{9, 0, 24'h001000}, '{12, 0, 24'h010000},
		'{10, 24'h7FFFFF, 24'h0}, '{10, 24'h800000, 24'h004000},
		'{11, 24'h800000, 24'h008000}, '{13, 0, 24'h020000},
		'{14, 0, 24'h040000}, '{15, 0, 24'h000001},
		'{16, 0, 24'h000002}, '{17, 0, 24'h000004},
		'{18, 0, 24'h080600}};

	initial begin
		forever #5 mclk = ~mclk;
	end

	mifs_host_model u_mifs_host_model (.mclk(mclk), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr));

	mifs_top u_mifs_top (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .supplyLowPin(supplyLowPin),
		.sagEvt(sagEvt), .crossTimeout(crossTimeout), .voltSign(voltSign),
		.lineCycleDone(lineCycleDone), .sampleValid(sampleValid),
		.voltSample(voltSample), .curSample(curSample), .waveformReady(waveformReady),
		.activeSign(activeSign), .reactiveSign(reactiveSign), .activeBit14(activeBit14),
		.reactiveBit14(reactiveBit14), .apparentBit15(apparentBit15),
		.irqNOut(irqNOut), .irqNOe(irqNOe));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic give_verdict();
		if (failures == 0 && samplesChecked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic fire(input int c, input logic [23:0] s);
		@(posedge mclk);
		case (c)
			0, 1, 2: sagEvt <= mifs_phase_t'(1 << c);
			3, 4, 5: crossTimeout <= mifs_phase_t'(1 << (c - 3));
			6, 7, 8: voltSign <= mifs_phase_t'(1 << (c - 6));
			9: lineCycleDone <= 1'b1;
			10: begin
				sampleValid <= 1'b1;
				voltSample <= s;
			end
			11: begin
				sampleValid <= 1'b1;
				curSample <= s;
			end
			12: waveformReady <= 1'b1;
			13: activeSign[0] <= ~activeSign[0];
			14: reactiveSign[2] <= ~reactiveSign[2];
			15: activeBit14[1] <= ~activeBit14[1];
			16: reactiveBit14[0] <= ~reactiveBit14[0];
			17: apparentBit15[2] <= 1'b1;
			default: voltSign <= 3'h1;
		endcase
		@(posedge mclk);
		// a then b on the very next crossing
		if (c == 18) begin
			voltSign <= 3'h2;
			@(posedge mclk);
		end
		// dropping the sign level is a falling crossing, which must stay silent
		sagEvt <= '0;
		crossTimeout <= '0;
		voltSign <= '0;
		lineCycleDone <= 1'b0;
		sampleValid <= 1'b0;
		waveformReady <= 1'b0;
		voltSample <= 24'h0;
		curSample <= 24'h0;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		u_mifs_host_model.xfer(1'b1, 12'h064, 1'b0, 32'h0, rd, err);
		chk("status after reset", rd, 32'h00002000);
		u_mifs_host_model.xfer(1'b0, 12'h064, 1'b0, 32'h0, rd, err);
		chk("reset flag one cycle", rd, 32'h0);
		fire(9, 24'h0);
		u_mifs_host_model.serviceIrq(st, rd);
		chk("line cycle mode off", rd, 32'h0);
		u_mifs_host_model.xfer(1'b0, 12'h080, 1'b1, 32'h0000001E, rd, err);
		foreach (rows[i]) begin
			fire(rows[i].code, rows[i].smp);
			u_mifs_host_model.serviceIrq(st, rd);
			chk("status", st, {8'h00, rows[i].exp});
			chk("clear on read", rd, {8'h00, rows[i].exp});
			u_mifs_host_model.xfer(1'b0, 12'h064, 1'b0, 32'h0, rd, err);
			chk("status cleared", rd, 32'h0);
		end
		u_mifs_host_model.xfer(1'b0, 12'h060, 1'b1, 32'hFFFFFFFF, rd, err);
		u_mifs_host_model.xfer(1'b0, 12'h060, 1'b0, 32'h0, rd, err);
		chk("mask readback", rd, 32'h000FDFFF);
		u_mifs_host_model.xfer(1'b0, 12'h060, 1'b1, 32'h00000008, rd, err);
		fire(1, 24'h0);
		@(negedge mclk);
		chk("irq masked", {31'h0, irqNOe}, 32'h0);
		fire(0, 24'h0);
		@(negedge mclk);
		chk("irq enabled", {30'h0, irqNOe, irqNOut}, 32'h2);
		u_mifs_host_model.serviceIrq(st, rd);
		@(negedge mclk);
		chk("irq released", {31'h0, irqNOe}, 32'h0);
		chk("ready", {31'h0, pready}, 32'h1);
		fire(0, 24'h0);
		u_mifs_host_model.xfer(1'b0, 12'h064, 1'b0, 32'h0, rd, err);
		chk("status before clear", rd, 32'h00000008);
		u_mifs_host_model.xfer(1'b0, 12'h064, 1'b1, 32'h00000008, rd, err);
		u_mifs_host_model.xfer(1'b0, 12'h064, 1'b0, 32'h0, rd, err);
		chk("write one to clear", rd, 32'h0);
		u_mifs_host_model.xfer(1'b0, 12'h084, 1'b1, 32'h00000100, rd, err);
		fire(10, 24'h000101);
		u_mifs_host_model.serviceIrq(st, rd);
		chk("programmed voltage peak", st, 32'h00004000);
		fire(2, 24'h0);
		u_mifs_host_model.xfer(1'b0, 12'h080, 1'b1, 32'h00000001, rd, err);
		u_mifs_host_model.xfer(1'b0, 12'h064, 1'b0, 32'h0, rd, err);
		chk("reset flag after soft reset", rd, 32'h00002000);
		u_mifs_host_model.xfer(1'b0, 12'h060, 1'b0, 32'h0, rd, err);
		chk("mask after soft reset", rd, 32'h0);
		u_mifs_host_model.xfer(1'b0, 12'h080, 1'b0, 32'h0, rd, err);
		chk("ctrl after soft reset", rd, 32'h0000001C);
		u_mifs_host_model.xfer(1'b0, 12'h064, 1'b0, 32'h0, rd, err);
		chk("status after soft reset", rd, 32'h0);
		fire(2, 24'h0);
		supplyLowPin <= 1'b1;
		repeat (3) @(posedge mclk);
		supplyLowPin <= 1'b0;
		repeat (2) @(posedge mclk);
		u_mifs_host_model.xfer(1'b1, 12'h064, 1'b0, 32'h0, rd, err);
		chk("status after supply low", rd, 32'h00002000);
		u_mifs_host_model.xfer(1'b0, 12'h064, 1'b0, 32'h0, rd, err);
		chk("supply low flag gone", rd, 32'h0);
		u_mifs_host_model.xfer(1'b0, 12'h0FC, 1'b0, 32'h0, rd, err);
		chk("unmapped data", rd, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		give_verdict();
	end
endmodule
